// >>> hdl/alsc_pkg.sv
// Package with opcodes, command and flag carriers and register map of the data unit
package alsc_pkg;

    localparam int ALSC_DATA_W = 16;
    localparam int ALSC_ADDR_W = 8;
    localparam int ALSC_EVT_W  = 5;

    // Register byte addresses
    localparam logic [7:0] ALSC_OFS_ACC    = 8'h00;
    localparam logic [7:0] ALSC_OFS_FLAGS  = 8'h04;
    localparam logic [7:0] ALSC_OFS_FAULT  = 8'h08;
    localparam logic [7:0] ALSC_OFS_CTRL   = 8'h0c;
    localparam logic [7:0] ALSC_OFS_STATUS = 8'h10;
    localparam logic [7:0] ALSC_OFS_MASK   = 8'h14;

    // Flag register bit positions
    localparam int ALSC_FLG_CARRY = 0;
    localparam int ALSC_FLG_ZERO  = 1;
    localparam int ALSC_FLG_OVF   = 2;

    // Control register bit positions
    localparam int ALSC_CTRL_EN = 0;

    // Event bit positions, shared by status and mask
    localparam int ALSC_EVT_ZERO   = 0;
    localparam int ALSC_EVT_CARRY  = 1;
    localparam int ALSC_EVT_OVF    = 2;
    localparam int ALSC_EVT_FAULT  = 3;
    localparam int ALSC_EVT_FCLR   = 4;

    // Reset values
    localparam logic [15:0] ALSC_RST_ACC   = 16'h0000;
    localparam logic [2:0]  ALSC_RST_FLAGS = 3'h0;
    localparam logic [15:0] ALSC_RST_FAULT = 16'h0000;
    localparam logic        ALSC_RST_EN    = 1'b1;
    localparam logic [4:0]  ALSC_RST_MASK  = 5'h00;

    // Largest four-digit decimal value
    localparam logic [15:0] ALSC_BCD_MAX   = 16'd9999;

    typedef enum logic [3:0] {
        ALSC_OP_NOP,
        ALSC_OP_AND,
        ALSC_OP_OR,
        ALSC_OP_SHR,
        ALSC_OP_SHL,
        ALSC_OP_DECODE,
        ALSC_OP_ENCODE,
        ALSC_OP_COMPLEMENT,
        ALSC_OP_BCD_TO_BINARY,
        ALSC_OP_BINARY_TO_BCD,
        ALSC_OP_EXTERNAL_FAULT_DIAG
    } alsc_op_e;

    typedef struct packed {
        logic        valid;
        logic        rung;
        alsc_op_e    op;
        logic [15:0] operand;
        logic [3:0]  shift_cnt;
    } alsc_cmd_s;

    typedef struct packed {
        logic ovf;
        logic zero;
        logic carry;
    } alsc_flags_s;

endpackage

// >>> hdl/alsc_conv.sv
// Combinational BCD and binary converters for the data unit
`timescale 1ns/100ps
module alsc_conv (
    input  wire logic [15:0] acc_in,
    output logic      [15:0] bin_out,
    output logic      [15:0] bcd_out,
    output logic             bcd_ovf_out
);
    import alsc_pkg::*;

    logic [19:0] digits;
    logic [15:0] bin_sum;

    // Digit weights summed in 16 bits; invalid digits above 9 are weighted as is
    assign bin_sum = 16'(acc_in[3:0])
                   + 16'(acc_in[7:4]) * 16'd10
                   + 16'(acc_in[11:8]) * 16'd100
                   + 16'(acc_in[15:12]) * 16'd1000;
    assign bin_out = bin_sum;

    // Shift-and-add-three over all sixteen input bits
    always_comb begin
        logic [35:0] work;
        work = {20'h00000, acc_in};
        for (int i = 0; i < 16; i++) begin
            for (int d = 0; d < 5; d++) begin
                if (work[16 + 4 * d +: 4] > 4'd4) begin
                    work[16 + 4 * d +: 4] = work[16 + 4 * d +: 4] + 4'd3;
                end
            end
            work = {work[34:0], 1'b0};
        end
        digits = work[35:16];
    end

    assign bcd_out     = digits[15:0];
    assign bcd_ovf_out = (acc_in > ALSC_BCD_MAX);

endmodule

// >>> hdl/alsc_unit.sv
// Accumulator logic, shift, convert and fault capture unit with register port
`timescale 1ns/100ps
module alsc_unit (
    input  wire logic                clk_sys_in,
    input  wire logic                rstn_in,
    input  wire alsc_pkg::alsc_cmd_s cmd_in,
    input  wire logic                clear_key_in,
    input  wire logic [7:0]          reg_addr_in,
    input  wire logic [15:0]         reg_wdata_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    output logic      [15:0]         reg_rdata_out,
    output logic      [15:0]         acc_out,
    output alsc_pkg::alsc_flags_s    flags_out,
    output logic      [15:0]         fault_num_out,
    output logic                     fault_shown_out,
    output logic                     irq_out
);
    import alsc_pkg::*;

    // Register state
    logic [15:0] acc_r;
    logic [15:0] acc_nxt;
    alsc_flags_s flags_r;
    alsc_flags_s flags_nxt;
    logic [15:0] fault_r;
    logic [15:0] fault_nxt;
    logic        shown_r;
    logic        shown_nxt;
    logic        en_r;
    logic [4:0]  status_r;
    logic [4:0]  status_nxt;
    logic [4:0]  mask_r;
    logic [15:0] rdata_r;
    logic        irq_r;

    // Clear key pin synchroniser and edge detect
    logic        key_meta_r;
    logic        key_sync_r;
    logic        key_prev_r;
    wire         key_press = key_sync_r & ~key_prev_r;

    // Register decode
    wire         wr_acc    = reg_wr_in & (reg_addr_in == ALSC_OFS_ACC);
    wire         wr_flags  = reg_wr_in & (reg_addr_in == ALSC_OFS_FLAGS);
    wire         wr_ctrl   = reg_wr_in & (reg_addr_in == ALSC_OFS_CTRL);
    wire         wr_status = reg_wr_in & (reg_addr_in == ALSC_OFS_STATUS);
    wire         wr_mask   = reg_wr_in & (reg_addr_in == ALSC_OFS_MASK);

    // Command decode; a disabled unit ignores the sequencer
    wire         cmd_go    = cmd_in.valid & en_r;
    wire         shift_ok  = (cmd_in.shift_cnt != 4'h0);
    wire         do_and    = cmd_go & (cmd_in.op == ALSC_OP_AND);
    wire         do_or     = cmd_go & (cmd_in.op == ALSC_OP_OR);
    wire         do_shr    = cmd_go & (cmd_in.op == ALSC_OP_SHR) & shift_ok;
    wire         do_shl    = cmd_go & (cmd_in.op == ALSC_OP_SHL) & shift_ok;
    wire         do_dec    = cmd_go & (cmd_in.op == ALSC_OP_DECODE);
    wire         do_enc    = cmd_go & (cmd_in.op == ALSC_OP_ENCODE);
    wire         do_inv    = cmd_go & (cmd_in.op == ALSC_OP_COMPLEMENT);
    wire         do_b2n    = cmd_go & (cmd_in.op == ALSC_OP_BCD_TO_BINARY);
    wire         do_n2b    = cmd_go & (cmd_in.op == ALSC_OP_BINARY_TO_BCD);
    wire         do_fault  = cmd_go & cmd_in.rung
                           & (cmd_in.op == ALSC_OP_EXTERNAL_FAULT_DIAG);

    // Datapath results
    wire  [15:0] and_res   = acc_r & cmd_in.operand;
    wire  [15:0] or_res    = acc_r | cmd_in.operand;
    wire  [31:0] shr_ext   = {acc_r, 16'h0000} >> cmd_in.shift_cnt;
    wire  [31:0] shl_ext   = {16'h0000, acc_r} << cmd_in.shift_cnt;
    wire  [15:0] shr_res   = shr_ext[31:16];
    wire  [15:0] shl_res   = shl_ext[15:0];
    wire         shr_lost  = |shr_ext[15:0];
    wire         shl_lost  = |shl_ext[31:16];
    wire  [15:0] dec_res   = 16'h0001 << acc_r[3:0];
    wire  [15:0] inv_res   = ~acc_r;
    logic [15:0] enc_res;
    logic [15:0] b2n_res;
    logic [15:0] n2b_res;
    logic        n2b_ovf;

    alsc_conv u_conv (
        .acc_in      (acc_r),
        .bin_out     (b2n_res),
        .bcd_out     (n2b_res),
        .bcd_ovf_out (n2b_ovf)
    );

    // Priority encoder: a later, higher bit overrides a lower one
    always_comb begin
        enc_res = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (acc_r[i]) begin
                enc_res = {12'h000, 4'(i)};
            end
        end
    end

    // Accumulator and flag update; a sequencer command beats a software write
    always_comb begin
        acc_nxt   = acc_r;
        flags_nxt = flags_r;
        if (wr_acc) begin
            acc_nxt = reg_wdata_in;
        end
        if (wr_flags) begin
            flags_nxt = alsc_flags_s'(reg_wdata_in[2:0]);
        end
        if (do_and) begin
            acc_nxt        = and_res;
            flags_nxt.zero = (and_res == 16'h0000);
        end else if (do_or) begin
            acc_nxt        = or_res;
            flags_nxt.zero = (or_res == 16'h0000);
        end else if (do_shr) begin
            acc_nxt         = shr_res;
            flags_nxt.carry = shr_lost;
            flags_nxt.zero  = (shr_res == 16'h0000);
        end else if (do_shl) begin
            acc_nxt         = shl_res;
            flags_nxt.carry = shl_lost;
            flags_nxt.zero  = (shl_res == 16'h0000);
        end else if (do_dec) begin
            acc_nxt = dec_res;
        end else if (do_enc) begin
            acc_nxt = enc_res;
        end else if (do_inv) begin
            acc_nxt = inv_res;
        end else if (do_b2n) begin
            acc_nxt = b2n_res;
        end else if (do_n2b) begin
            acc_nxt       = n2b_res;
            flags_nxt.ovf = n2b_ovf;
        end
    end

    // Fault capture; each active operation overwrites, so the last one stays
    always_comb begin
        fault_nxt = fault_r;
        shown_nxt = shown_r;
        if (key_press) begin
            shown_nxt = 1'b0;
        end
        if (do_fault) begin
            fault_nxt = cmd_in.operand;
            shown_nxt = 1'b1;
        end
    end

    // Sticky events; a new event wins over a write-one-to-clear
    wire  [4:0]  evt_set;
    assign evt_set[ALSC_EVT_ZERO]  = flags_nxt.zero & ~flags_r.zero;
    assign evt_set[ALSC_EVT_CARRY] = flags_nxt.carry & ~flags_r.carry;
    assign evt_set[ALSC_EVT_OVF]   = flags_nxt.ovf & ~flags_r.ovf;
    assign evt_set[ALSC_EVT_FAULT] = do_fault;
    assign evt_set[ALSC_EVT_FCLR]  = key_press & shown_r & ~do_fault;

    wire  [4:0]  status_clr = wr_status ? reg_wdata_in[4:0] : 5'h00;
    assign status_nxt = (status_r & ~status_clr) | evt_set;

    // Read mux; unmapped addresses read zero
    logic [15:0] rd_mux;
    always_comb begin
        case (reg_addr_in)
            ALSC_OFS_ACC:    rd_mux = acc_r;
            ALSC_OFS_FLAGS:  rd_mux = {13'h0000, flags_r};
            ALSC_OFS_FAULT:  rd_mux = fault_r;
            ALSC_OFS_CTRL:   rd_mux = {15'h0000, en_r};
            ALSC_OFS_STATUS: rd_mux = {11'h000, status_r};
            ALSC_OFS_MASK:   rd_mux = {11'h000, mask_r};
            default:         rd_mux = 16'h0000;
        endcase
    end

    // Clear key pin: first stage feeds only the second
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            key_meta_r <= 1'b0;
            key_sync_r <= 1'b0;
            key_prev_r <= 1'b0;
        end else begin
            key_meta_r <= clear_key_in;
            key_sync_r <= key_meta_r;
            key_prev_r <= key_sync_r;
        end
    end

    // Sixteen-bit accumulator and flag coils
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            acc_r   <= ALSC_RST_ACC;
            flags_r <= alsc_flags_s'(ALSC_RST_FLAGS);
        end else begin
            acc_r   <= acc_nxt;
            flags_r <= flags_nxt;
        end
    end

    // Fault number register and display request
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            fault_r <= ALSC_RST_FAULT;
            shown_r <= 1'b0;
        end else begin
            fault_r <= fault_nxt;
            shown_r <= shown_nxt;
        end
    end

    // Control, status and mask
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            en_r     <= ALSC_RST_EN;
            mask_r   <= ALSC_RST_MASK;
            status_r <= 5'h00;
        end else begin
            if (wr_ctrl) begin
                en_r <= reg_wdata_in[ALSC_CTRL_EN];
            end
            if (wr_mask) begin
                mask_r <= reg_wdata_in[4:0];
            end
            status_r <= status_nxt;
        end
    end

    // Registered read data and interrupt; irq is built from the next status, so it changes in the same cycle as status
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            rdata_r <= 16'h0000;
            irq_r   <= 1'b0;
        end else begin
            rdata_r <= reg_rd_in ? rd_mux : 16'h0000;
            irq_r   <= |(status_nxt & mask_r);
        end
    end

    assign reg_rdata_out   = rdata_r;
    assign acc_out         = acc_r;
    assign flags_out       = flags_r;
    assign fault_num_out   = fault_r;
    assign fault_shown_out = shown_r;
    assign irq_out         = irq_r;

endmodule

// >>> testbench/alsc_unit_asserts.sv
// Checker for the accumulator data unit ports
`timescale 1ns/100ps
module alsc_chk
    import alsc_pkg::*;
(
    input wire logic         clk_sys_in,
    input wire logic         rstn_in,
    input wire alsc_cmd_s    cmd_in,
    input wire logic         clear_key_in,
    input wire logic [7:0]   reg_addr_in,
    input wire logic [15:0]  reg_wdata_in,
    input wire logic         reg_wr_in,
    input wire logic         reg_rd_in,
    input wire logic [15:0]  reg_rdata_out,
    input wire logic [15:0]  acc_out,
    input wire alsc_flags_s  flags_out,
    input wire logic [15:0]  fault_num_out,
    input wire logic         fault_shown_out,
    input wire logic         irq_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    // Enable copy rebuilt from bus writes, since only ports are visible here
    logic          en_q;
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            en_q <= ALSC_RST_EN;
        end else if (reg_wr_in && reg_addr_in == ALSC_OFS_CTRL) begin
            en_q <= reg_wdata_in[ALSC_CTRL_EN];
        end
    end
    wire logic     v  = cmd_in.valid & en_q;
    wire logic     sh = cmd_in.shift_cnt != 4'h0;
    wire alsc_op_e o  = cmd_in.op;

    and_result_a: assert property (v && o == ALSC_OP_AND |=>
        acc_out == ($past(acc_out) & $past(cmd_in.operand))) else $error("and result wrong");
    or_result_a: assert property (v && o == ALSC_OP_OR |=>
        acc_out == ($past(acc_out) | $past(cmd_in.operand))) else $error("or result wrong");
    zero_flag_a: assert property (v && (o inside {ALSC_OP_AND, ALSC_OP_OR} ||
        (o inside {ALSC_OP_SHR, ALSC_OP_SHL} && sh)) |=> flags_out.zero == (acc_out == 16'h0))
        else $error("zero flag wrong");
    shift_right_a: assert property (v && o == ALSC_OP_SHR && sh |=>
        acc_out == $past(acc_out) >> $past(cmd_in.shift_cnt)) else $error("right shift wrong");
    shift_left_a: assert property (v && o == ALSC_OP_SHL && sh |=>
        acc_out == $past(acc_out) << $past(cmd_in.shift_cnt)) else $error("left shift wrong");
    carry_right_a: assert property (v && o == ALSC_OP_SHR && sh |=> flags_out.carry ==
        (($past(acc_out) & ~(16'hffff << $past(cmd_in.shift_cnt))) != 16'h0))
        else $error("carry wrong");
    carry_left_a: assert property (v && o == ALSC_OP_SHL && sh |=> flags_out.carry ==
        (($past(acc_out) & ~(16'hffff >> $past(cmd_in.shift_cnt))) != 16'h0))
        else $error("left carry wrong");
    decode_pos_a: assert property (v && o == ALSC_OP_DECODE |=>
        acc_out == 16'h0001 << $past(acc_out[3:0])) else $error("decode wrong");
    invert_all_a: assert property (v && o == ALSC_OP_COMPLEMENT |=>
        acc_out == ~$past(acc_out)) else $error("invert wrong");
    overflow_flag_a: assert property (v && o == ALSC_OP_BINARY_TO_BCD |=>
        flags_out.ovf == ($past(acc_out) > ALSC_BCD_MAX)) else $error("overflow wrong");
    fault_capture_a: assert property (v && cmd_in.rung && o == ALSC_OP_EXTERNAL_FAULT_DIAG |=>
        fault_num_out == $past(cmd_in.operand) && fault_shown_out)
        else $error("fault capture wrong");
    flags_keep_a: assert property (v && o inside {ALSC_OP_DECODE, ALSC_OP_ENCODE,
        ALSC_OP_COMPLEMENT, ALSC_OP_BCD_TO_BINARY} |=> $stable(flags_out))
        else $error("flags moved");
    rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 16'h0)
        else $error("read data not idle");
endmodule
bind alsc_unit alsc_chk i_chk (.clk_sys_in, .rstn_in, .cmd_in, .clear_key_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .acc_out, .flags_out,
    .fault_num_out, .fault_shown_out, .irq_out);

// >>> testbench/alsc_seq.sv
// Sequencer model issuing one queued command a cycle
`timescale 1ns/100ps
module alsc_seq
    import alsc_pkg::*;
(
    input  wire logic clk_sys_in,
    output alsc_cmd_s cmd_out
);
    alsc_cmd_s q[$];
    initial cmd_out = '0;
    always @(posedge clk_sys_in) begin
        if (q.size() != 0) begin
            cmd_out <= q.pop_front();
        end else begin
            // Idle operand keeps toggling so a stale value never looks valid
            cmd_out.valid   <= 1'b0;
            cmd_out.operand <= ~cmd_out.operand;
        end
    end
endmodule

// >>> testbench/accumulator_logic_shift_convert_unit_bench.sv
// Self-checking bench for the accumulator data unit
`timescale 1ns/100ps
`define CHK(g, e) chk(16'(g), 16'(e))
module accumulator_logic_shift_convert_unit_bench;
    import alsc_pkg::*;
    logic        clk_sys_in = 0, rstn_in = 0, clear_key_in = 0, wr = 0, rd_s = 0;
    logic [7:0]  addr = 0;
    logic [15:0] wdata = 0, rdata, acc_out, fault_num_out, v;
    logic        fault_shown_out, irq_out;
    alsc_flags_s flags_out;
    alsc_cmd_s   cmd;
    int mismatches = 0, tests_run = 0, seed = 16988, ma, mc, mz, mo, a, d, n, op, k;
    logic [7:0]  ra[4] = '{ALSC_OFS_FLAGS, ALSC_OFS_CTRL, ALSC_OFS_MASK, 8'h20};
    logic [15:0] re[4] = '{16'h0, 16'h1, 16'h0, 16'h0};

    always #5 clk_sys_in = ~clk_sys_in;
    alsc_unit i_dut (.clk_sys_in, .rstn_in, .cmd_in(cmd), .clear_key_in, .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
        .acc_out, .flags_out, .fault_num_out, .fault_shown_out, .irq_out);
    alsc_seq i_seq (.clk_sys_in, .cmd_out(cmd));

    task chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task finish_test;
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task go(input int c);
        repeat (c) @(posedge clk_sys_in);
        #1;
    endtask
    task wreg(input logic [7:0] ad, input logic [15:0] wd);
        @(posedge clk_sys_in);
        wr <= 1'b1; addr <= ad; wdata <= wd;
        @(posedge clk_sys_in);
        wr <= 1'b0;
        #1;
    endtask
    task rreg(input logic [7:0] ad);
        @(posedge clk_sys_in);
        rd_s <= 1'b1; addr <= ad;
        @(posedge clk_sys_in);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask
    task push(input int o, input int dd, input int nn, input int r);
        alsc_cmd_s c;
        c = '{1'b1, r[0], alsc_op_e'(o), dd[15:0], nn[3:0]};
        i_seq.q.push_back(c);
    endtask
    function automatic int enc(input int x);
        enc = 0;
        for (int j = 0; j < 16; j++) if (x[j]) enc = j;
    endfunction
    task model(input int o);
        case (o)
            1: begin ma = ma & d; mz = ma == 0; end
            2: begin ma = ma | d; mz = ma == 0; end
            3: if (n != 0) begin mc = (ma & ((1 << n) - 1)) != 0; ma = ma >> n; mz = ma == 0; end
            4: if (n != 0) begin mc = (ma >> (16 - n)) != 0; ma = (ma << n) & 'hffff; mz = ma == 0; end
            5: ma = 1 << (ma & 15);
            6: ma = enc(ma);
            7: ma = ~ma & 'hffff;
            8: ma = ((ma >> 12) * 1000 + (ma >> 8 & 15) * 100 + (ma >> 4 & 15) * 10 + (ma & 15)) & 'hffff;
            default: begin
                mo = ma > 9999; ma = ma % 10000;
                ma = (ma / 1000) << 12 | (ma / 100 % 10) << 8 | (ma / 10 % 10) << 4 | ma % 10;
            end
        endcase
    endtask

    initial begin
        ma = 0; mc = 0; mz = 0; mo = 0;
        repeat (4) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        #1;
        for (k = 0; k < 4; k++) begin rreg(ra[k]); `CHK(v, re[k]); end
        for (int i = 0; i < 60; i++) begin
            a = $random(seed) & ((i % 3 != 0) ? 'hffff : 'h1fff);
            if (i % 5 == 0) a = 0;
            d = (i % 4 == 0) ? 0 : $random(seed) & 'hffff;
            n = (i < 9) ? 15 : $random(seed) & 15;
            op = i % 9 + 1;
            wreg(ALSC_OFS_ACC, a[15:0]);
            ma = a;
            push(op, d, n, 1);
            go(2);
            model(op);
            `CHK(acc_out, ma);
            `CHK(flags_out, {mo[0], mz[0], mc[0]});
            rreg(ALSC_OFS_ACC); `CHK(v, ma);
        end
        // A disabled unit must ignore the sequencer entirely
        wreg(ALSC_OFS_CTRL, 16'h0000);
        push(7, 0, 0, 1);
        go(2);
        `CHK(acc_out, ma);
        `CHK(flags_out, {mo[0], mz[0], mc[0]});
        wreg(ALSC_OFS_CTRL, 16'h0001);
        wreg(ALSC_OFS_MASK, 16'h0008);
        wreg(ALSC_OFS_STATUS, 16'h001f);
        push(10, 'h1111, 0, 0); go(2);
        `CHK(fault_shown_out, 1'b0);
        push(10, 'h1111, 0, 1); push(10, 'h2222, 0, 1); go(3);
        `CHK(fault_num_out, 16'h2222);
        `CHK({irq_out, fault_shown_out}, 2'b11);
        wreg(ALSC_OFS_STATUS, 16'h0008); go(1);
        `CHK(irq_out, 1'b0);
        @(posedge clk_sys_in);
        clear_key_in <= 1'b1;
        k = 0;
        while (fault_shown_out !== 1'b0 && k < 8) begin go(1); k++; end
        `CHK(fault_shown_out, 1'b0);
        `CHK(fault_num_out, 16'h2222);
        if (k == 8) mismatches++;
        clear_key_in <= 1'b0;
        rreg(ALSC_OFS_STATUS);
        `CHK(v, 16'h0010);
        `CHK(irq_out, 1'b0);
        wreg(ALSC_OFS_FAULT, 16'h0000);
        rreg(ALSC_OFS_FAULT); `CHK(v, 16'h2222);
        finish_test;
    end
endmodule
